/* hw/vrc_top.sv */
// voltage reference control: apb registers, converter override, bandgap and ready status
// Notes on behaviour
// RULE1 - generator-on bit switches the reference generator on or off
// RULE2 - reference reaches its pin only while pin-output bit is set
// RULE3 - sensor powered after reset; sensor-off bit powers it down, clearing restores
// RULE4 - while converter holds control, effective states follow converter controls
// RULE5 - busy while any peripheral uses generator; control writes then ignored; the one-shot bits are still taken while busy
// RULE6 - bandgap mode static if any user asks static, else sample
// RULE7 - sample mode powers bandgap on need; static until no users remain
// RULE8 - bandgap-active flag true while any peripheral uses the bandgap
// RULE9 - generator-active flag true when generator on and ready
// RULE10 - buffered-bandgap ready flag true once that voltage is usable
// RULE11 - variable-reference ready flag true once selected reference is usable
// RULE12 - bandgap one-shot bit starts one generation, hardware clears it
// RULE13 - reference one-shot bit starts one generation, hardware clears it
// RULE14 - level select picks 1.2, 1.45 or 2.5 V; resets to 1.2 V
// RULE15 - software level governs only while the unit itself holds control
// RULE16 - control bits and status flags read zero after reset
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`include "vrc_cfg.svh"
module vrc_top (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 conv_take,
   input  wire logic                 conv_gen_on,
   input  wire logic                 conv_pin_out,
   input  wire logic                 conv_tsens_off,
   input  wire logic [1:0]           conv_level,
   input  wire logic [`VRC_NPER-1:0] per_gen_use,
   input  wire logic [`VRC_NPER-1:0] per_bgap_use,
   input  wire logic [`VRC_NPER-1:0] per_bgap_static,
   input  wire logic [`VRC_NPER-1:0] per_bgap_need,
   output logic                      ref_gen_on,
   output logic                      ref_pin_out_en,
   output logic                      temp_sensor_on,
   output logic [1:0]                ref_level_sel,
   output logic                      bgap_power,
   output logic                      bgap_static,
   output logic                      gen_busy,
   output logic                      gen_active,
   output logic                      bgap_active,
   output logic                      bgap_buf_ready,
   output logic                      var_ref_ready
);
   vrc_pkg::vrc_top_s st_q;
   vrc_pkg::vrc_top_s st_d;
   logic              acc;
   logic              wr_ctrl;
   logic              busy;
   logic              local_need;
   logic              buf_en;
   logic              var_en;
   logic              buf_rdy;
   logic              var_rdy;
   logic [31:0]       ctrl_word;
   logic [31:0]       stat_word;

   // zero wait states: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign acc     = psel && penable;
   assign wr_ctrl = acc && pwrite && (paddr == `VRC_A_CTRL);
   assign busy    = (|per_gen_use) || conv_take;   // see RULE5

   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[`VRC_C_GEN_ON]               = st_q.gen_on;
      ctrl_word[`VRC_C_PIN_OUT]              = st_q.pin_out;
      ctrl_word[`VRC_C_TSENS_OFF]            = st_q.tsens_off;
      ctrl_word[`VRC_C_LVL_HI:`VRC_C_LVL_LO] = st_q.level;
      ctrl_word[`VRC_C_BGAP_OT]              = st_q.bgap_ot;
      ctrl_word[`VRC_C_REF_OT]               = st_q.ref_ot;
   end

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[`VRC_S_GEN_ACT]  = gen_active;
      stat_word[`VRC_S_BUSY]     = busy;
      stat_word[`VRC_S_BGAP_ACT] = bgap_active;
      stat_word[`VRC_S_BGAP_STAT] = bgap_static;
      stat_word[`VRC_S_BUF_RDY]  = bgap_buf_ready;
      stat_word[`VRC_S_VAR_RDY]  = var_ref_ready;
   end

   always_comb begin
      st_d         = st_q;
      // one-shot sequences: a set bit is taken, cleared, and runs until ready
      if (st_q.bgap_st == vrc_pkg::VRC_OT_IDLE) begin
         if (st_q.bgap_ot) begin
            st_d.bgap_ot = 1'b0;                           // see RULE12
            st_d.bgap_st = vrc_pkg::VRC_OT_RUN;
         end
      end else begin
         if (buf_rdy) begin
            st_d.bgap_st = vrc_pkg::VRC_OT_IDLE;
         end
      end
      if (st_q.ref_st == vrc_pkg::VRC_OT_IDLE) begin
         if (st_q.ref_ot) begin
            st_d.ref_ot = 1'b0;                            // see RULE13
            st_d.ref_st = vrc_pkg::VRC_OT_RUN;
         end
      end else begin
         if (var_rdy) begin
            st_d.ref_st = vrc_pkg::VRC_OT_IDLE;
         end
      end
      if (acc && !pwrite) begin
         if (paddr == `VRC_A_CTRL) begin
            st_d.prdata = ctrl_word;
         end else if (paddr == `VRC_A_STATUS) begin
            st_d.prdata = stat_word;
         end else begin
            st_d.prdata  = 32'h0000_0000;
         end
      end
      if (acc && pwrite) begin
         if (paddr == `VRC_A_CTRL) begin
            // a new one-shot request wins over the hardware clear
            if (pwdata[`VRC_C_BGAP_OT]) begin
               st_d.bgap_ot = 1'b1;                        // see RULE12
            end
            if (pwdata[`VRC_C_REF_OT]) begin
               st_d.ref_ot = 1'b1;                         // see RULE13
            end
            if (!busy) begin                               // see RULE5
               st_d.gen_on    = pwdata[`VRC_C_GEN_ON];     // see RULE1
               st_d.pin_out   = pwdata[`VRC_C_PIN_OUT];    // see RULE2
               st_d.tsens_off = pwdata[`VRC_C_TSENS_OFF];  // see RULE3
               // the unused code would select no level, so it is refused
               if (pwdata[`VRC_C_LVL_HI:`VRC_C_LVL_LO] != `VRC_LVL_RESERVED) begin
                  st_d.level = pwdata[`VRC_C_LVL_HI:`VRC_C_LVL_LO]; // see RULE14
               end
            end
         end
      end
      if (conv_take) begin                                 // see RULE4
         st_d.eff_gen_on   = conv_gen_on;
         st_d.eff_pin_out  = conv_pin_out;
         st_d.eff_tsens_on = !conv_tsens_off;
         st_d.eff_level    = conv_level;                   // see RULE15
      end else begin
         st_d.eff_gen_on   = st_q.gen_on;                  // see RULE1
         st_d.eff_pin_out  = st_q.pin_out;                 // see RULE2
         st_d.eff_tsens_on = !st_q.tsens_off;              // see RULE3
         st_d.eff_level    = st_q.level;                   // see RULE15
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q              <= '0;                          // see RULE16
         st_q.level        <= vrc_pkg::VRC_LVL_1V2;        // see RULE14
         st_q.eff_level    <= vrc_pkg::VRC_LVL_1V2;
         st_q.eff_tsens_on <= 1'b1;                        // see RULE3
      end else begin
         st_q <= st_d;
      end
   end

   // the generator and one-shots need the bandgap regardless of peripherals
   assign local_need = st_q.eff_gen_on || (st_q.bgap_st == vrc_pkg::VRC_OT_RUN)
                       || (st_q.ref_st == vrc_pkg::VRC_OT_RUN);
   assign buf_en     = bgap_power && (st_q.eff_gen_on || (st_q.bgap_st == vrc_pkg::VRC_OT_RUN));
   assign var_en     = bgap_power && (st_q.eff_gen_on || (st_q.ref_st == vrc_pkg::VRC_OT_RUN));

   vrc_bgap_arb u_arb (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .use_req    (per_bgap_use),
      .static_req (per_bgap_static),
      .need       (per_bgap_need),
      .local_need (local_need),
      .active     (bgap_active),
      .stat       (bgap_static),
      .power      (bgap_power)
   );

   vrc_settle #(.CYC(8'(`VRC_BGAP_SET_CYC))) u_buf_settle (
      .sys_clk (sys_clk),
      .rst     (rst),
      .en      (buf_en),
      .ready   (buf_rdy)
   );

   vrc_settle #(.CYC(8'(`VRC_REF_SET_CYC))) u_var_settle (
      .sys_clk (sys_clk),
      .rst     (rst),
      .en      (var_en),
      .ready   (var_rdy)
   );

   assign prdata         = st_q.prdata;
   // decoded in the access cycle itself, since pready never waits
   assign pslverr        = acc && (paddr != `VRC_A_CTRL) && (paddr != `VRC_A_STATUS);
   assign ref_gen_on     = st_q.eff_gen_on;
   assign ref_pin_out_en = st_q.eff_pin_out && st_q.eff_gen_on;
   assign temp_sensor_on = st_q.eff_tsens_on;
   assign ref_level_sel  = st_q.eff_level;
   assign gen_busy       = busy;
   assign gen_active     = st_q.eff_gen_on && var_rdy;     // see RULE9
   assign bgap_buf_ready = buf_rdy;                        // see RULE10
   assign var_ref_ready  = var_rdy;                        // see RULE11

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_busy_locks_on: assert property (busy && wr_ctrl |=> $stable(st_q.gen_on) && $stable(st_q.level)) // see RULE5
      else $error("control changed while generator busy");

   a_conv_follow: assert property (conv_take |=> ref_gen_on == $past(conv_gen_on)) // see RULE4
      else $error("generator state ignores converter control");

   a_pin_follow: assert property (!conv_take |=> ref_pin_out_en == $past(st_q.pin_out && st_q.gen_on)) // see RULE2
      else $error("pin output does not follow its control bit");

   a_gen_follow: assert property (!conv_take ##1 !conv_take |-> ref_gen_on == $past(st_q.gen_on)) // see RULE1
      else $error("generator does not follow its control bit");

   a_tsens_follow: assert property (!conv_take |=> temp_sensor_on == !$past(st_q.tsens_off)) // see RULE3
      else $error("sensor power does not follow its control bit");

   a_level_sw: assert property (!conv_take |=> ref_level_sel == $past(st_q.level)) // see RULE15
      else $error("level does not follow software select");

   a_level_legal: assert property (st_q.level != `VRC_LVL_RESERVED) // see RULE14
      else $error("level select holds the unused code");

   a_bgap_ot_clear: assert property (st_q.bgap_ot && st_q.bgap_st == vrc_pkg::VRC_OT_IDLE && !wr_ctrl
                                     |=> !st_q.bgap_ot && st_q.bgap_st == vrc_pkg::VRC_OT_RUN) // see RULE12
      else $error("bandgap one-shot bit not taken");

   a_ref_ot_clear: assert property (st_q.ref_ot && st_q.ref_st == vrc_pkg::VRC_OT_IDLE && !wr_ctrl
                                    |=> !st_q.ref_ot ##0 st_q.ref_st == vrc_pkg::VRC_OT_RUN) // see RULE13
      else $error("reference one-shot bit not taken");

   a_mode_static: assert property ((|(per_bgap_use & per_bgap_static)) |=> bgap_static) // see RULE6
      else $error("static request did not make mode static");

   a_mode_sample: assert property (!(|(per_bgap_use & per_bgap_static)) |=> !bgap_static) // see RULE6
      else $error("mode static with no static request");

   a_bgap_act: assert property (bgap_active == $past(|per_bgap_use) || $past(rst)) // see RULE8
      else $error("bandgap active flag wrong");

   a_static_power: assert property ((|(per_bgap_use & per_bgap_static)) |=> bgap_power) // see RULE7
      else $error("static bandgap not powered");

   a_idle_unpowered: assert property (!(|per_bgap_use) && !local_need |=> !bgap_power) // see RULE7
      else $error("bandgap powered with no user");

   a_gen_ready: assert property (gen_active |-> ref_gen_on && bgap_power) // see RULE9
      else $error("generator active while off");

   a_var_rdy_settle: assert property ($rose(var_ref_ready) |-> $past(var_en, 8)) // see RULE11
      else $error("reference ready before settling");

   a_buf_rdy_settle: assert property ($rose(bgap_buf_ready) |-> $past(buf_en, 5)) // see RULE10
      else $error("buffered bandgap ready before settling");

   c_oneshot_ref: cover property (st_q.ref_st == vrc_pkg::VRC_OT_RUN ##[1:20] var_ref_ready);
   c_busy_write:  cover property (busy && wr_ctrl);
   c_conv_take:   cover property (conv_take && ref_gen_on);
   c_static_mode: cover property (bgap_static && bgap_power);
endmodule : vrc_top

/* hw/vrc_cfg.svh */
// register offsets, field positions, the reserved level code and timing for the reference control
`ifndef VRC_CFG_SVH
`define VRC_CFG_SVH
`define VRC_NPER         2
`define VRC_A_CTRL       32'h0000_0000
`define VRC_A_STATUS     32'h0000_0004
`define VRC_C_GEN_ON     0
`define VRC_C_PIN_OUT    1
`define VRC_C_TSENS_OFF  2
`define VRC_C_LVL_LO     4
`define VRC_C_LVL_HI     5
`define VRC_C_BGAP_OT    6
`define VRC_C_REF_OT     7
`define VRC_S_GEN_ACT    0
`define VRC_S_BUSY       1
`define VRC_S_BGAP_ACT   2
`define VRC_S_BGAP_STAT  3
`define VRC_S_BUF_RDY    4
`define VRC_S_VAR_RDY    5
`define VRC_LVL_RESERVED 2'h3
`define VRC_BGAP_SET_NS  50
`define VRC_REF_SET_NS   80
`define VRC_CLK_NS       10
`define VRC_BGAP_SET_CYC ((`VRC_BGAP_SET_NS + `VRC_CLK_NS - 1) / `VRC_CLK_NS)
`define VRC_REF_SET_CYC  ((`VRC_REF_SET_NS + `VRC_CLK_NS - 1) / `VRC_CLK_NS)
`define VRC_CNT_W        8
`endif

/* hw/vrc_pkg.sv */
// types shared by the reference control modules
package vrc_pkg;
   typedef enum logic [1:0] {
      VRC_LVL_1V2,
      VRC_LVL_1V45,
      VRC_LVL_2V5
   } vrc_level_e;

   typedef enum logic {
      VRC_OT_IDLE,
      VRC_OT_RUN
   } vrc_ot_e;

   typedef struct packed {
      logic [7:0] cnt;
   } vrc_settle_s;

   typedef struct packed {
      logic active;
      logic stat;
      logic power;
   } vrc_arb_s;

   typedef struct packed {
      logic        gen_on;
      logic        pin_out;
      logic        tsens_off;
      logic [1:0]  level;
      logic        bgap_ot;
      logic        ref_ot;
      vrc_ot_e     bgap_st;
      vrc_ot_e     ref_st;
      logic        eff_gen_on;
      logic        eff_pin_out;
      logic        eff_tsens_on;
      logic [1:0]  eff_level;
      logic [31:0] prdata;
   } vrc_top_s;
endpackage : vrc_pkg

/* hw/vrc_settle.sv */
// settling timer: ready once enable has stood for the settle count
`timescale 1ns/1ns
`include "vrc_cfg.svh"
module vrc_settle #(
   parameter logic [7:0] CYC = 8'h01
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic en,
   output logic      ready
);
   vrc_pkg::vrc_settle_s st_q;
   vrc_pkg::vrc_settle_s st_d;

   always_comb begin
      st_d = st_q;
      if (!en) begin
         st_d.cnt = 8'h00;
      end else if (st_q.cnt != CYC) begin
         st_d.cnt = st_q.cnt + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // dropping enable clears ready at once
   assign ready = en && (st_q.cnt == CYC);
endmodule : vrc_settle

/* hw/vrc_bgap_arb.sv */
// bandgap arbitration across requesting peripherals
`timescale 1ns/1ns
`include "vrc_cfg.svh"
module vrc_bgap_arb (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic [`VRC_NPER-1:0] use_req,
   input  wire logic [`VRC_NPER-1:0] static_req,
   input  wire logic [`VRC_NPER-1:0] need,
   input  wire logic                 local_need,
   output logic                      active,
   output logic                      stat,
   output logic                      power
);
   vrc_pkg::vrc_arb_s st_q;
   vrc_pkg::vrc_arb_s st_d;

   always_comb begin
      st_d        = st_q;
      st_d.active = |use_req;                  // see RULE8
      st_d.stat   = |(use_req & static_req);   // see RULE6
      // sample mode powers only on demand; static holds while any user remains
      st_d.power  = local_need || (st_d.stat ? st_d.active : |(use_req & need)); // see RULE7
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign active = st_q.active;
   assign stat   = st_q.stat;
   assign power  = st_q.power;
endmodule : vrc_bgap_arb

/* tb/vrc_periph_model.sv */
// partner model: analog peripherals asking for the generator and the bandgap
`timescale 1ns/1ns
`include "vrc_cfg.svh"
module vrc_periph_model (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 want_gen,
   input  wire logic [`VRC_NPER-1:0] want_bgap,
   input  wire logic [`VRC_NPER-1:0] want_static,
   input  wire logic [`VRC_NPER-1:0] want_need,
   output logic                      per_gen_use,
   output logic [`VRC_NPER-1:0]      per_bgap_use,
   output logic [`VRC_NPER-1:0]      per_bgap_static,
   output logic [`VRC_NPER-1:0]      per_bgap_need
);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         per_gen_use     <= 1'b0;
         per_bgap_use    <= '0;
         per_bgap_static <= '0;
         per_bgap_need   <= '0;
      end else begin
         per_gen_use     <= want_gen;
         per_bgap_use    <= want_bgap;
         per_bgap_static <= want_static & want_bgap;
         // a static user never signals sample need; need without use is meaningless
         per_bgap_need   <= want_need & want_bgap & ~want_static;
      end
   end
endmodule : vrc_periph_model

/* tb/tb.sv */
// self-checking bench for the reference control block
`timescale 1ns/1ns
`include "vrc_cfg.svh"
module tb;
   logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, d;
   logic        conv_take, conv_gen_on, conv_pin_out, conv_tsens_off;
   logic [1:0]  conv_level, ref_level_sel, w_bgap, w_stat, w_need, p_use, p_stat, p_need;
   logic        w_gen, p_gen, ref_gen_on, ref_pin_out_en, temp_sensor_on, bgap_power, bgap_static;
   logic        gen_busy, gen_active, bgap_active, bgap_buf_ready, var_ref_ready, seen, err;
   int          n_fail, n_tests, cyc;

   vrc_periph_model peri (.sys_clk(sys_clk), .rst(rst), .want_gen(w_gen), .want_bgap(w_bgap),
      .want_static(w_stat), .want_need(w_need), .per_gen_use(p_gen), .per_bgap_use(p_use),
      .per_bgap_static(p_stat), .per_bgap_need(p_need));

   vrc_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_take(conv_take), .conv_gen_on(conv_gen_on), .conv_pin_out(conv_pin_out),
      .conv_tsens_off(conv_tsens_off), .conv_level(conv_level), .per_gen_use({1'b0, p_gen}),
      .per_bgap_use(p_use), .per_bgap_static(p_stat), .per_bgap_need(p_need),
      .ref_gen_on(ref_gen_on), .ref_pin_out_en(ref_pin_out_en), .temp_sensor_on(temp_sensor_on),
      .ref_level_sel(ref_level_sel), .bgap_power(bgap_power), .bgap_static(bgap_static),
      .gen_busy(gen_busy), .gen_active(gen_active), .bgap_active(bgap_active),
      .bgap_buf_ready(bgap_buf_ready), .var_ref_ready(var_ref_ready));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test

   // ceiling well above the roughly 155 cycles the sequence needs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         finish_test;
      end
   end

   task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_reg

   task chk_sig(input string nm, input logic [1:0] e, input logic [1:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_sig

   task apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int k;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
         err = pslverr;
      end while (pready !== 1'b1 && k < 50);
      psel    <= 1'b0;
      penable <= 1'b0;
      // read data is registered on the completing edge, so look just after it
      #1 rd = prdata;
   endtask : apb

   task wr(input logic [31:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, d);
   endtask : wr

   task settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : settle

   task end_test(input string nm);
      $display("test %s done", nm);
   endtask : end_test

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {conv_take, conv_gen_on, conv_pin_out, conv_tsens_off, conv_level} = '0;
      {w_gen, w_bgap, w_stat, w_need} = '0;
      {n_fail, n_tests, cyc} = '0;
      rst = 1'b1;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      settle(1);
      chk_sig("sensor", 2'h1, {1'b0, temp_sensor_on});
      chk_sig("level", vrc_pkg::VRC_LVL_1V2, ref_level_sel);
      apb(1'b0, `VRC_A_CTRL, '0, d);
      chk_reg("ctrl", 32'h0000_0000, d);
      chk_sig("slverr", 2'h0, {1'b0, err});
      apb(1'b0, `VRC_A_STATUS, '0, d);
      chk_reg("status", 32'h0000_0000, d);
      apb(1'b0, 32'h0000_0010, '0, d);
      chk_reg("unmapped", 32'h0000_0000, d);
      chk_sig("slverr", 2'h1, {1'b0, err});
      end_test("reset");

      wr(`VRC_A_CTRL, 32'h0000_0023);
      settle(2);
      chk_sig("gen_on", 2'h1, {1'b0, ref_gen_on});
      chk_sig("pin", 2'h1, {1'b0, ref_pin_out_en});
      chk_sig("level", vrc_pkg::VRC_LVL_2V5, ref_level_sel);
      settle(12);
      apb(1'b0, `VRC_A_STATUS, '0, d);
      chk_reg("status", 32'h0000_0031, d);
      wr(`VRC_A_CTRL, 32'h0000_0025);
      settle(2);
      chk_sig("pin", 2'h0, {1'b0, ref_pin_out_en});
      chk_sig("sensor", 2'h0, {1'b0, temp_sensor_on});
      wr(`VRC_A_CTRL, 32'h0000_0021);
      settle(2);
      chk_sig("sensor", 2'h1, {1'b0, temp_sensor_on});
      end_test("control");

      w_gen <= 1'b1;
      settle(3);
      chk_sig("busy", 2'h1, {1'b0, gen_busy});
      wr(`VRC_A_CTRL, 32'h0000_0004);
      settle(2);
      chk_sig("gen_on", 2'h1, {1'b0, ref_gen_on});
      chk_sig("sensor", 2'h1, {1'b0, temp_sensor_on});
      apb(1'b0, `VRC_A_STATUS, '0, d);
      chk_reg("status", 32'h0000_0033, d);
      w_gen <= 1'b0;
      settle(3);
      end_test("busy");

      conv_tsens_off <= 1'b1;
      conv_take      <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         conv_level <= 2'(i);
         settle(3);
         chk_sig("conv level", 2'(i), ref_level_sel);
      end
      chk_sig("conv gen", 2'h0, {1'b0, ref_gen_on});
      chk_sig("conv sensor", 2'h0, {1'b0, temp_sensor_on});
      conv_take <= 1'b0;
      settle(3);
      chk_sig("level", vrc_pkg::VRC_LVL_2V5, ref_level_sel);
      wr(`VRC_A_CTRL, 32'h0000_0000);
      end_test("converter");

      w_bgap <= 2'h3;
      w_stat <= 2'h1;
      settle(4);
      chk_sig("static", 2'h1, {1'b0, bgap_static});
      chk_sig("bgap pwr", 2'h1, {1'b0, bgap_power});
      apb(1'b0, `VRC_A_STATUS, '0, d);
      chk_reg("status", 32'h0000_000c, d);
      w_stat <= 2'h0;
      settle(4);
      chk_sig("static", 2'h0, {1'b0, bgap_static});
      chk_sig("bgap pwr", 2'h0, {1'b0, bgap_power});
      w_need <= 2'h2;
      settle(3);
      chk_sig("bgap pwr", 2'h1, {1'b0, bgap_power});
      w_bgap <= 2'h0;
      w_need <= 2'h0;
      settle(4);
      chk_sig("active", 2'h0, {1'b0, bgap_active});
      end_test("bandgap");

      wr(`VRC_A_CTRL, 32'h0000_0040);
      apb(1'b0, `VRC_A_CTRL, '0, d);
      chk_reg("ctrl", 32'h0000_0000, d);
      seen = 1'b0;
      repeat (20) begin
         settle(1);
         if (bgap_buf_ready === 1'b1) seen = 1'b1;
      end
      chk_sig("buf ready", 2'h1, {1'b0, seen});
      chk_sig("buf ready", 2'h0, {1'b0, bgap_buf_ready});
      wr(`VRC_A_CTRL, 32'h0000_0080);
      apb(1'b0, `VRC_A_CTRL, '0, d);
      chk_reg("ctrl", 32'h0000_0000, d);
      seen = 1'b0;
      repeat (20) begin
         settle(1);
         if (var_ref_ready === 1'b1) seen = 1'b1;
      end
      chk_sig("var ready", 2'h1, {1'b0, seen});
      chk_sig("var ready", 2'h0, {1'b0, var_ref_ready});
      end_test("oneshot");
      finish_test;
   end
endmodule : tb
